//--- bench/pscf_port_strap_bench.sv
`default_nettype none
`define CHK(got, exp) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			num_errors++; \
			$display("unexpected at %0t: got %h want %h", $time, got, exp); \
		end \
	end
module pscf_port_strap_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import pscf_pkg::*;
	localparam int RST_CYC = 12;
	localparam int SET_CYC = 3;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic s_vc = 1'h0;
	logic s_inv = 1'h0;
	logic s_pl = 1'h0;
	logic s_clk = 1'h0;
	logic [2:1] s_slot = 2'h0;
	logic sel = 1'h0;
	logic [2:1] plugged = 2'h0;
	logic [2:0] awake = 3'h7;
	logic [2:0] pstate = 3'h0;
	logic [2:1] occ_n;
	logic [2:0] pin_lvl;
	logic [2:0] pin_out;
	logic [2:0] pin_oe;
	pscf_cfg_s cfg;
	logic cfg_ok;
	logic [2:1] dev;
	logic [2:1] dwn_n;
	logic [2:0] refclk;
	logic [2:0] pll;
	logic [2:0] l1;
	int num_errors = 0;
	int compares = 0;

	always #5 clk = ~clk;

	pscf_port_strap #(.DWN_RST_CYC(RST_CYC), .SETTLE_CYC(SET_CYC))
		pscf_port_strap_inst (.CORE_CLK(clk), .SYS_RST(rst),
		.SECOND_CHANNEL_STRAP(s_vc), .RX_INVERT_DETECT_OFF(s_inv),
		.LARGE_PAYLOAD_STRAP(s_pl), .SHARED_REFCLK_STRAP(s_clk),
		.SLOT_PRESENT_STRAP(s_slot), .SIDEBAND_PIN_SELECT(sel),
		.SLOT_OCCUPIED_N(occ_n), .PORT_STATE(pstate),
		.CLOCK_REQUEST_N(pin_lvl), .PORT_STATE_OUT(pin_out),
		.SIDEBAND_OE(pin_oe), .CONFIG(cfg), .CONFIG_VALID(cfg_ok),
		.DEV_PRESENT(dev), .DOWNSTREAM_RESET_N(dwn_n),
		.REFCLK_ENABLE(refclk), .PLL_ENABLE(pll), .L1_SUBSTATE(l1));

	pscf_slot_model pscf_slot_model_inst (.plugged(plugged), .awake(awake),
		.pin_out(pin_out), .pin_oe(pin_oe), .occupied_n(occ_n),
		.pin_level(pin_lvl));

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	task automatic apply_reset;
		@(posedge clk);
		rst <= 1'h1;
		@(posedge clk);
		#1;
		`CHK(cfg, CFG_RST)
		`CHK({cfg_ok, dwn_n, pin_oe}, 6'h00)
		`CHK({refclk, pll, l1}, 9'h1f8)
		@(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		#1;
	endtask : apply_reset

	task automatic t_straps;
		pscf_cfg_s exp;
		logic [1:0] v;
		for (int k = 0; k < 4; k++)
		begin
			v = 2'(k);
			@(posedge clk);
			{s_vc, s_inv, s_pl, s_clk, s_slot} <= {v[0], ~v[0], v[1], ^v, v};
			apply_reset();
			exp = {v[0], ~v[0], v[0], v[1] ? MPS_512B : MPS_256B, ^v, v, 1'h0};
			`CHK({cfg_ok, cfg}, {1'h1, exp})
			@(posedge clk);
			{s_vc, s_inv, s_pl, s_clk, s_slot} <= ~{v[0], ~v[0], v[1], ^v, v};
			repeat (2) @(posedge clk);
			#1;
			`CHK(cfg, exp)
		end
		$display("straps test done");
	endtask : t_straps

	task automatic t_plug;
		logic [2:1] m;
		for (int p = 1; p < 3; p++)
		begin
			m = 2'(1 << (p - 1));
			@(posedge clk);
			plugged <= m;
			@(posedge clk);
			#1;
			`CHK({dev, dwn_n}, {m, ~m})
			repeat (RST_CYC - 1) @(posedge clk);
			#1;
			`CHK(dwn_n, ~m)
			@(posedge clk);
			#1;
			`CHK(dwn_n, 2'h3)
			@(posedge clk);
			plugged <= 2'h0;
			@(posedge clk);
			#1;
			`CHK({dev, dwn_n}, 4'h3)
		end
		$display("plug test done");
	endtask : t_plug

	task automatic t_clkreq;
		logic [2:0] m;
		for (int p = 0; p < 3; p++)
		begin
			m = 3'(1 << p);
			@(posedge clk);
			awake <= ~m;
			@(posedge clk);
			#1;
			`CHK({pin_oe, refclk, pll, l1}, {3'h0, ~m, ~m, m})
			@(posedge clk);
			awake <= 3'h7;
			@(posedge clk);
			#1;
			`CHK({refclk, pll, l1}, {3'h7, ~m, m})
			repeat (SET_CYC - 1) @(posedge clk);
			#1;
			`CHK(pll, ~m)
			@(posedge clk);
			#1;
			`CHK({pll, l1}, 6'h38)
		end
		$display("clock request test done");
	endtask : t_clkreq

	task automatic t_status;
		@(posedge clk);
		sel <= 1'h1;
		apply_reset();
		for (int k = 5; k < 8; k++)
		begin
			@(posedge clk);
			pstate <= 3'(k);
			@(posedge clk);
			#1;
			`CHK({pin_oe, pin_out}, {3'h7, 3'(k)})
		end
		@(posedge clk);
		sel <= 1'h0;
		apply_reset();
		repeat (2) @(posedge clk);
		#1;
		`CHK({pin_oe, pin_out, l1}, 9'h000)
		$display("status test done");
	endtask : t_status

	initial
	begin
		apply_reset();
		t_straps();
		t_plug();
		t_clkreq();
		t_status();
		close_out();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		close_out();
	end
endmodule : pscf_port_strap_bench
`default_nettype wire

//--- bench/pscf_slot_model.sv
`default_nettype none
module pscf_slot_model
(
	// requests from the bench
	input wire logic [2:1] plugged,
	input wire logic [2:0] awake,
	// shared pins from the device
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe,
	// to the device
	output logic [2:1] occupied_n,
	output logic [2:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ns;
	// presence pin pulled low while a card sits in the slot
	assign occupied_n = ~plugged;
	// request low while awake; device owns the pin only in status mode
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & ~awake);
endmodule : pscf_slot_model
`default_nettype wire

//--- logic/pscf_clkreq.sv
`default_nettype none
module pscf_clkreq
#(
	parameter int SETTLE_CYC = pscf_pkg::REFCLK_SETTLE_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic l1_allow,
	input wire logic req_n,
	// clock power state
	output logic refclk_en,
	output logic pll_en,
	output logic l1_sub
);
	import pscf_pkg::*;

	localparam int CW = $clog2(SETTLE_CYC + 1);
	localparam logic [CW-1:0] CNT_LOAD = CW'(SETTLE_CYC);
	localparam logic [CW-1:0] CNT_LAST = CW'(1);

	pscf_crq_e state_r, state_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic refclk_en_r, refclk_en_nxt;
	logic pll_en_r, pll_en_nxt;
	logic l1_sub_r, l1_sub_nxt;

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			CRQ_ACTIVE:
			begin
				if (l1_allow && req_n)
				begin
					state_nxt = CRQ_L1;
				end
			end
			CRQ_L1:
			begin
				if (!l1_allow || !req_n)
				begin
					state_nxt = CRQ_WAKE;
					cnt_nxt = CNT_LOAD;
				end
			end
			CRQ_WAKE:
			begin
				if (cnt_r <= CNT_LAST)
				begin
					state_nxt = CRQ_ACTIVE;
				end
				else
				begin
					cnt_nxt = cnt_r - CNT_LAST;
				end
			end
			default:
			begin
				state_nxt = CRQ_ACTIVE;
			end
		endcase
		refclk_en_nxt = (state_nxt != CRQ_L1);
		pll_en_nxt = (state_nxt == CRQ_ACTIVE);
		l1_sub_nxt = (state_nxt != CRQ_ACTIVE);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= CRQ_ACTIVE;
			cnt_r <= '0;
			refclk_en_r <= 1'h1;
			pll_en_r <= 1'h1;
			l1_sub_r <= 1'h0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			refclk_en_r <= refclk_en_nxt;
			pll_en_r <= pll_en_nxt;
			l1_sub_r <= l1_sub_nxt;
		end
	end

	assign refclk_en = refclk_en_r;
	assign pll_en = pll_en_r;
	assign l1_sub = l1_sub_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_l1_entry_off: assert property (
		state_r == CRQ_ACTIVE && l1_allow && req_n
		|=> !refclk_en && !pll_en && l1_sub)
		else $error("clock request release did not enter l1 substate");
	a_wake_refclk: assert property (
		state_r == CRQ_L1 && !req_n |=> refclk_en && !pll_en && l1_sub)
		else $error("clock request did not restore reference clock");
	a_wake_pll_time: assert property (
		$rose(refclk_en) |-> ##SETTLE_CYC (pll_en && !l1_sub))
		else $error("pll not enabled after reference clock settle time");
	c_l1_exit: cover property ($fell(l1_sub));
endmodule : pscf_clkreq
`default_nettype wire

//--- logic/pscf_pkg.sv
`default_nettype none
package pscf_pkg;
	// port numbering: port 0 upstream, ports 1..2 downstream
	localparam int NUM_PORTS = 3;
	localparam int DS_LO = 1;
	localparam int DS_HI = 2;

	// max payload size capability encodings
	localparam logic [2:0] MPS_256B = 3'h1;
	localparam logic [2:0] MPS_512B = 3'h2;

	// timing
	localparam int CLK_MHZ = 100;
	localparam int NS_PER_US = 1000;
	localparam int DWN_RST_NS = 1000;
	localparam int DWN_RST_CYC =
		(DWN_RST_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam int REFCLK_SETTLE_NS = 100;
	localparam int REFCLK_SETTLE_CYC =
		(REFCLK_SETTLE_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;

	// settings captured from the straps at reset release
	typedef struct packed {
		logic second_vc_on;
		logic vc0_pooled;
		logic rx_inv_det_en;
		logic [2:0] mps_cap;
		logic shared_refclk;
		logic [DS_HI:DS_LO] slot_attached;
		logic status_mode;
	} pscf_cfg_s;

	localparam pscf_cfg_s CFG_RST = '0;

	// clock request controller states
	typedef enum logic [1:0] {
		CRQ_ACTIVE = 2'b00,
		CRQ_L1 = 2'b01,
		CRQ_WAKE = 2'b10
	} pscf_crq_e;
endpackage : pscf_pkg
`default_nettype wire

//--- logic/pscf_port_strap.sv
// Function
// - second-channel strap high enables VC1 beside VC0, no resource sharing.
// - second-channel strap low pools VC1 resources into VC0, no VC1.
// - invert-detect-off strap high disables rx polarity detection, low enables.
// - large-payload strap high advertises 512B payload, otherwise 256B.
// - low slot-occupied input means device present, high means absent.
// - shared-refclk strap high reports common platform reference clock.
// - slot-present strap bit marks port as slot, else chip-to-chip.
// - select low: pins are clock requests; release stops clock, enters L1.
// - request asserted restores clock, then enables PLL and leaves L1 substate together.
// - select high: pins driven as per-port status outputs.
// - downstream reset held during system reset or after a plug-in.
// - system reset initialises all internal state.
`default_nettype none
module pscf_port_strap
#(
	parameter int DWN_RST_CYC = pscf_pkg::DWN_RST_CYC,
	parameter int SETTLE_CYC = pscf_pkg::REFCLK_SETTLE_CYC
)
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	// configuration straps
	input wire logic SECOND_CHANNEL_STRAP,
	input wire logic RX_INVERT_DETECT_OFF,
	input wire logic LARGE_PAYLOAD_STRAP,
	input wire logic SHARED_REFCLK_STRAP,
	input wire logic [pscf_pkg::DS_HI:pscf_pkg::DS_LO] SLOT_PRESENT_STRAP,
	input wire logic SIDEBAND_PIN_SELECT,
	// slot presence
	input wire logic [pscf_pkg::DS_HI:pscf_pkg::DS_LO] SLOT_OCCUPIED_N,
	// per-port status from the link logic
	input wire logic [pscf_pkg::NUM_PORTS-1:0] PORT_STATE,
	// shared sideband pins
	input wire logic [pscf_pkg::NUM_PORTS-1:0] CLOCK_REQUEST_N,
	output logic [pscf_pkg::NUM_PORTS-1:0] PORT_STATE_OUT,
	output logic [pscf_pkg::NUM_PORTS-1:0] SIDEBAND_OE,
	// captured settings
	output var pscf_pkg::pscf_cfg_s CONFIG,
	output logic CONFIG_VALID,
	// downstream slots
	output logic [pscf_pkg::DS_HI:pscf_pkg::DS_LO] DEV_PRESENT,
	output logic [pscf_pkg::DS_HI:pscf_pkg::DS_LO] DOWNSTREAM_RESET_N,
	// clock power control
	output logic [pscf_pkg::NUM_PORTS-1:0] REFCLK_ENABLE,
	output logic [pscf_pkg::NUM_PORTS-1:0] PLL_ENABLE,
	output logic [pscf_pkg::NUM_PORTS-1:0] L1_SUBSTATE
);
	import pscf_pkg::*;

	localparam int HCW = $clog2(DWN_RST_CYC + 1);
	localparam logic [HCW-1:0] HOLD_LOAD = HCW'(DWN_RST_CYC);
	localparam logic [HCW-1:0] HOLD_STEP = HCW'(1);

	logic sampled_r, sampled_nxt;
	pscf_cfg_s cfg_r, cfg_nxt;
	logic [DS_HI:DS_LO] present_r, present_nxt;
	logic [DS_HI:DS_LO] rst_n_r, rst_n_nxt;
	logic [DS_HI:DS_LO][HCW-1:0] hold_r, hold_nxt;
	logic [NUM_PORTS-1:0] pin_o_r, pin_o_nxt;
	logic [NUM_PORTS-1:0] pin_oe_r, pin_oe_nxt;
	logic l1_allow;

	// strap capture, once after reset release
	always_comb
	begin
		sampled_nxt = 1'h1;
		cfg_nxt = cfg_r;
		if (!sampled_r)
		begin
			cfg_nxt.second_vc_on = SECOND_CHANNEL_STRAP;
			cfg_nxt.vc0_pooled = !SECOND_CHANNEL_STRAP;
			cfg_nxt.rx_inv_det_en = !RX_INVERT_DETECT_OFF;
			if (LARGE_PAYLOAD_STRAP)
			begin
				cfg_nxt.mps_cap = MPS_512B;
			end
			else
			begin
				cfg_nxt.mps_cap = MPS_256B;
			end
			cfg_nxt.shared_refclk = SHARED_REFCLK_STRAP;
			cfg_nxt.slot_attached = SLOT_PRESENT_STRAP;
			cfg_nxt.status_mode = SIDEBAND_PIN_SELECT;
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			sampled_r <= 1'h0;
			cfg_r <= CFG_RST;
		end
		else
		begin
			sampled_r <= sampled_nxt;
			cfg_r <= cfg_nxt;
		end
	end

	// presence tracking and downstream reset
	always_comb
	begin
		present_nxt = ~SLOT_OCCUPIED_N;
		hold_nxt = hold_r;
		rst_n_nxt = '0;
		for (int i = DS_LO; i <= DS_HI; i++)
		begin
			if (sampled_r && present_nxt[i] && !present_r[i])
			begin
				hold_nxt[i] = HOLD_LOAD;
			end
			else if (hold_r[i] != '0)
			begin
				hold_nxt[i] = hold_r[i] - HOLD_STEP;
			end
			rst_n_nxt[i] = sampled_r && (hold_nxt[i] == '0);
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			present_r <= '0;
			hold_r <= '0;
			rst_n_r <= '0;
		end
		else
		begin
			present_r <= present_nxt;
			hold_r <= hold_nxt;
			rst_n_r <= rst_n_nxt;
		end
	end

	// shared pins: status outputs or clock request inputs
	always_comb
	begin
		pin_oe_nxt = '0;
		pin_o_nxt = '0;
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			if (sampled_r && cfg_r.status_mode)
			begin
				pin_oe_nxt[p] = 1'h1;
				pin_o_nxt[p] = PORT_STATE[p];
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			pin_oe_r <= '0;
			pin_o_r <= '0;
		end
		else
		begin
			pin_oe_r <= pin_oe_nxt;
			pin_o_r <= pin_o_nxt;
		end
	end

	// clock request handling per port
	assign l1_allow = sampled_r && !cfg_r.status_mode;

	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++)
		begin : g_crq
			pscf_clkreq #(
				.SETTLE_CYC(SETTLE_CYC)
			) u_crq (
				.clk(CORE_CLK),
				.rst(SYS_RST),
				.l1_allow(l1_allow),
				.req_n(CLOCK_REQUEST_N[g]),
				.refclk_en(REFCLK_ENABLE[g]),
				.pll_en(PLL_ENABLE[g]),
				.l1_sub(L1_SUBSTATE[g])
			);
		end
	endgenerate

	assign CONFIG = cfg_r;
	assign CONFIG_VALID = sampled_r;
	assign DEV_PRESENT = present_r;
	assign DOWNSTREAM_RESET_N = rst_n_r;
	assign PORT_STATE_OUT = pin_o_r;
	assign SIDEBAND_OE = pin_oe_r;

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (SYS_RST);

	a_second_vc_on: assert property (
		$rose(sampled_r) |-> CONFIG.second_vc_on == $past(SECOND_CHANNEL_STRAP))
		else $error("second channel setting does not follow strap");
	a_vc0_pool: assert property (
		$rose(sampled_r) && !$past(SECOND_CHANNEL_STRAP)
		|-> CONFIG.vc0_pooled && !CONFIG.second_vc_on)
		else $error("vc1 resources not pooled into vc0");
	a_rx_detect_en: assert property (
		$rose(sampled_r) |-> CONFIG.rx_inv_det_en != $past(RX_INVERT_DETECT_OFF))
		else $error("polarity detection setting wrong");
	a_payload_cap: assert property (
		$rose(sampled_r) |-> CONFIG.mps_cap ==
		($past(LARGE_PAYLOAD_STRAP) ? MPS_512B : MPS_256B))
		else $error("payload capability wrong");
	a_dev_present: assert property (
		sampled_r |-> DEV_PRESENT == ~$past(SLOT_OCCUPIED_N))
		else $error("presence does not follow slot input");
	a_shared_clk: assert property (
		$rose(sampled_r) |-> CONFIG.shared_refclk == $past(SHARED_REFCLK_STRAP))
		else $error("shared refclk setting wrong");
	a_slot_attach: assert property (
		$rose(sampled_r) |-> CONFIG.slot_attached == $past(SLOT_PRESENT_STRAP))
		else $error("slot attach setting wrong");
	a_status_drive: assert property (
		sampled_r && CONFIG.status_mode
		|=> SIDEBAND_OE == '1 && PORT_STATE_OUT == $past(PORT_STATE))
		else $error("status pins not driven with port state");
	a_plug_reset: assert property (
		sampled_r && $fell(SLOT_OCCUPIED_N[DS_LO])
		|=> (!DOWNSTREAM_RESET_N[DS_LO])[*8])
		else $error("plug-in did not hold downstream reset");
	a_reset_init: assert property (
		$rose(sampled_r) |-> DOWNSTREAM_RESET_N == '0 && SIDEBAND_OE == '0)
		else $error("state not initialised by reset");
	a_cfg_hold: assert property (
		sampled_r && $past(sampled_r) |-> $stable(CONFIG))
		else $error("settings changed after capture");

	c_status_mode: cover property ($rose(sampled_r) && CONFIG.status_mode);
	c_plug_in: cover property (sampled_r && $fell(SLOT_OCCUPIED_N[DS_LO]));
	c_l1_enter: cover property ($rose(L1_SUBSTATE[0]) && !CONFIG.status_mode);
endmodule : pscf_port_strap
`default_nettype wire
